/* prot_pkg.sv */
package prot_pkg;

   // =====================================================================
   // Timing: delays in microseconds, converted to 200 MHz cycles.
   // =====================================================================
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned OC_DELAY_US      = 10;
   localparam int unsigned SC_DELAY_US      = 1;
   localparam int unsigned OC_REL_US        = 10;
   localparam int unsigned XC_DELAY_US      = 15;
   localparam int unsigned XC_REL_US        = 15;
   localparam int unsigned OCH_DELAY_US     = 20;
   localparam int unsigned OCH_REL_US       = 20;
   localparam int unsigned OD_DELAY_US      = 20;
   localparam int unsigned OD_REL_US        = 20;
   localparam int unsigned SHORT_DIV        = 8;
   localparam int unsigned CNT_W            = 16;

   localparam logic [CNT_W-1:0] OC_CYC   = CNT_W'(OC_DELAY_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] SC_CYC   = CNT_W'(SC_DELAY_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] OCR_CYC  = CNT_W'(OC_REL_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] XC_CYC   = CNT_W'(XC_DELAY_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] XCR_CYC  = CNT_W'(XC_REL_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] OCH_CYC  = CNT_W'(OCH_DELAY_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] OCHR_CYC = CNT_W'(OCH_REL_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] OD_CYC   = CNT_W'(OD_DELAY_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] ODR_CYC  = CNT_W'(OD_REL_US * CLK_MHZ);

   // =====================================================================
   // Comparator bundle and pin drive bundle.
   // =====================================================================
   typedef struct packed {
      logic over_charge;    // Either cell at or above over-charge level.
      logic charge_ok;      // Both cells at or below over-charge release level.
      logic over_dis;       // Either cell at or below over-discharge level.
      logic dis_ok;         // Both cells at or above over-discharge level.
      logic over_cur;       // Sense node at or above over-current level.
      logic short_cir;      // Sense node at or above short-circuit level.
      logic xs_charger;     // Sense-to-ground at or below charger level.
      logic stby_rel;       // Sense node at or below stand-by release level.
      logic zero_v_ok;      // Supply-to-sense at zero-volt charge level.
   } cmp_t;

   typedef struct packed {
      logic chg_en;         // Charge-block gate, high allows charging.
      logic dis_en;         // Discharge-block gate, high allows discharge.
      logic pull_up;        // Sense node to positive supply.
      logic pull_dn;        // Sense node to ground.
      logic standby;        // Stand-by mode.
   } drv_t;

   typedef enum logic [4:0] {
      D_NORMAL = 5'h01,
      D_OC     = 5'h02,
      D_SC     = 5'h04,
      D_OD     = 5'h08,
      D_OCREL  = 5'h10
   } dis_st_t;

endpackage : prot_pkg

/* sync3.sv */
`timescale 1ns/100ps
// =====================================================================
// Three-stage input synchroniser with agreement filter.
// =====================================================================
module sync3
(
   input  wire logic clk,    // System clock.
   input  wire logic rst_n,  // Synchronous reset, active low.
   input  wire logic din,    // Asynchronous input.
   output logic      dout    // Filtered level.
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // The first stage feeds only the second to keep metastability contained.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            dout <= s3_q;
      end
   end
endmodule : sync3

/* delay_cnt.sv */
`timescale 1ns/100ps
// =====================================================================
// Qualification timer: counts while cond holds, restarts when it drops.
// =====================================================================
module delay_cnt
(
   input  wire logic                    clk,     // System clock.
   input  wire logic                    rst_n,   // Synchronous reset, active low.
   input  wire logic                    cond,    // Qualifying condition.
   input  wire logic [prot_pkg::CNT_W-1:0] limit, // Terminal count.
   output logic                         done     // High once cond held limit cycles.
);
   logic [prot_pkg::CNT_W-1:0] cnt_q;

   // Any drop of the condition restarts the count from zero.
   always_ff @(posedge clk)
   begin
      if (!rst_n || !cond)
         cnt_q <= '0;
      else if (cnt_q < limit)
         cnt_q <= cnt_q + 1'b1;
   end

   assign done = cond && (cnt_q >= limit);
endmodule : delay_cnt

/* prot_seq.sv */
`timescale 1ns/100ps
module prot_seq
(
   input  wire logic           clk,          // System clock.
   input  wire logic           rst_n,        // Synchronous reset, active low.
   input  wire prot_pkg::cmp_t cmp_pins,     // Raw comparator results.
   input  wire logic           test_short,   // Delay shortening pin.
   output prot_pkg::drv_t      drv           // Gate and switch drive, registered.
);
   // =====================================================================
   // Input synchronisation.
   // =====================================================================
   prot_pkg::cmp_t cmp;
   logic           tst;

   // Each analog comparator is a pin from outside the clock domain.
   genvar gi;
   generate
      for (gi = 0; gi < $bits(prot_pkg::cmp_t); gi++)
      begin : g_sync
         sync3 u_sync (.clk(clk), .rst_n(rst_n), .din(cmp_pins[gi]), .dout(cmp[gi]));
      end
   endgenerate

   sync3 u_tsync (.clk(clk), .rst_n(rst_n), .din(test_short), .dout(tst));

   // =====================================================================
   // Terminal counts.
   // =====================================================================
   // Shortening divides counter delays; the short-circuit delay is fixed.
   function automatic logic [prot_pkg::CNT_W-1:0] pick(input logic [prot_pkg::CNT_W-1:0] n,
                                                       input logic t);
      pick = t ? (n / prot_pkg::CNT_W'(prot_pkg::SHORT_DIV)) : n;
   endfunction : pick

   // =====================================================================
   // State.
   // =====================================================================
   prot_pkg::dis_st_t dst_q;
   logic              och_q;     // Over-charge state, charge blocked.
   logic              xc_q;      // Excessive charger state.
   logic              och_first_q;
   logic              stby_q;
   logic              zv_q;      // Zero-volt charge enable.

   logic oc_done, sc_done, ocr_done, od_done, odr_done;
   logic och_done, ochr_done, xc_done, xcr_done;
   logic dis_hi;
   logic oc_cond, xc_cond, od_cond;

   assign dis_hi  = (dst_q == prot_pkg::D_NORMAL);
   // Over-current detection is aborted once over-charge is in force.
   assign oc_cond = dis_hi && cmp.over_cur && !och_q;
   // Over-discharge waits while over-charge detection is pending, but not once it is held.
   assign od_cond = dis_hi && cmp.over_dis && !(cmp.over_charge && !och_q);
   // Charger detection timing only runs with the discharge gate high.
   assign xc_cond = dis_hi && cmp.xs_charger && !xc_q;

   delay_cnt u_oc   (.clk(clk), .rst_n(rst_n), .cond(oc_cond),
                     .limit(pick(prot_pkg::OC_CYC, tst)), .done(oc_done));
   delay_cnt u_sc   (.clk(clk), .rst_n(rst_n), .cond(dis_hi && cmp.short_cir),
                     .limit(prot_pkg::SC_CYC), .done(sc_done));
   delay_cnt u_ocr  (.clk(clk), .rst_n(rst_n),
                     .cond(dst_q == prot_pkg::D_OCREL && !cmp.over_cur),
                     .limit(pick(prot_pkg::OCR_CYC, tst)), .done(ocr_done));
   delay_cnt u_od   (.clk(clk), .rst_n(rst_n), .cond(od_cond),
                     .limit(pick(prot_pkg::OD_CYC, tst)), .done(od_done));
   delay_cnt u_odr  (.clk(clk), .rst_n(rst_n),
                     .cond(dst_q == prot_pkg::D_OD && !stby_q && cmp.dis_ok),
                     .limit(pick(prot_pkg::ODR_CYC, tst)), .done(odr_done));
   delay_cnt u_och  (.clk(clk), .rst_n(rst_n), .cond(!och_q && cmp.over_charge),
                     .limit(pick(prot_pkg::OCH_CYC, tst)), .done(och_done));
   delay_cnt u_ochr (.clk(clk), .rst_n(rst_n), .cond(och_q && cmp.charge_ok),
                     .limit(pick(prot_pkg::OCHR_CYC, tst)), .done(ochr_done));
   delay_cnt u_xc   (.clk(clk), .rst_n(rst_n), .cond(xc_cond),
                     .limit(pick(prot_pkg::XC_CYC, tst)), .done(xc_done));
   delay_cnt u_xcr  (.clk(clk), .rst_n(rst_n), .cond(xc_q && !cmp.xs_charger),
                     .limit(pick(prot_pkg::XCR_CYC, tst)), .done(xcr_done));

   // =====================================================================
   // Discharge-side state machine.
   // =====================================================================
   // Short-circuit is checked first because its delay is the shorter one.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         dst_q <= prot_pkg::D_NORMAL;
      else
      begin
         unique case (dst_q)
            prot_pkg::D_NORMAL:
            begin
               if (sc_done)
                  dst_q <= prot_pkg::D_SC;
               else if (od_done)
                  dst_q <= prot_pkg::D_OD;
               else if (oc_done)
                  dst_q <= prot_pkg::D_OC;
            end
            prot_pkg::D_OC,
            prot_pkg::D_SC:
            begin
               if (!cmp.over_cur)
                  dst_q <= prot_pkg::D_OCREL;
            end
            prot_pkg::D_OCREL:
            begin
               if (cmp.over_cur)
                  dst_q <= prot_pkg::D_OC;
               else if (ocr_done)
                  dst_q <= prot_pkg::D_NORMAL;
            end
            prot_pkg::D_OD:
            begin
               if (odr_done)
                  dst_q <= prot_pkg::D_NORMAL;
            end
            default: dst_q <= prot_pkg::D_NORMAL;
         endcase
      end
   end

   // Stand-by entry follows over-discharge unless over-charge came first.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         stby_q <= 1'b0;
      else if (dst_q == prot_pkg::D_NORMAL && od_done && !sc_done)
         stby_q <= !och_q;
      else if (stby_q && cmp.stby_rel)
         stby_q <= 1'b0;
   end

   // =====================================================================
   // Charge-side state.
   // =====================================================================
   // Over-charge latches after its delay and releases after its own delay.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         och_q <= 1'b0;
      else if (och_done)
         och_q <= 1'b1;
      else if (ochr_done)
         och_q <= 1'b0;
   end

   // Remember whether over-charge held before any discharge-side fault.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         och_first_q <= 1'b0;
      else if (!och_q)
         och_first_q <= 1'b0;
      else if (dis_hi)
         och_first_q <= 1'b1;
   end

   // The charger flag only changes after a full qualification period.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         xc_q <= 1'b0;
      else if (xc_done)
         xc_q <= 1'b1;
      else if (xcr_done)
         xc_q <= 1'b0;
   end

   // Zero-volt charging tracks the supply-to-sense comparator.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         zv_q <= 1'b0;
      else
         zv_q <= cmp.zero_v_ok;
   end

   // =====================================================================
   // Output drive.
   // =====================================================================
   // The discharge gate stays off through the release wait, so a load that
   // comes back early cannot slip past the over-current release delay.
   // The sense switches follow the discharge-side state: pull-up in D_OD, pull-down in D_OC, D_SC and D_OCREL.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         drv <= '{chg_en: 1'b1, dis_en: 1'b1, pull_up: 1'b0, pull_dn: 1'b0, standby: 1'b0};
      else
      begin
         drv.chg_en  <= (!och_q && !xc_q) || zv_q;
         drv.dis_en  <= dis_hi;
         drv.pull_up <= dst_q == prot_pkg::D_OD;
         drv.pull_dn <= (dst_q == prot_pkg::D_OC || dst_q == prot_pkg::D_SC
                         || dst_q == prot_pkg::D_OCREL);
         drv.standby <= stby_q && dst_q == prot_pkg::D_OD;
      end
   end

   // =====================================================================
   // Checks.
   // =====================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_sc_enter;
      dis_hi && sc_done;
   endsequence

   a_sc_blocks_dis: assert property (s_sc_enter |-> ##2 !drv.dis_en)
      else $error("Short circuit did not block discharge.");
   a_sc_no_standby: assert property (dst_q == prot_pkg::D_SC
      |-> ##1 !drv.standby && drv.pull_dn)
      else $error("Short circuit state drove wrong sense switches.");
   a_oc_release: assert property (dst_q == prot_pkg::D_SC && !cmp.over_cur
      |=> dst_q == prot_pkg::D_OCREL)
      else $error("Over-current release not entered.");
   a_xc_sets: assert property (xc_done |=> xc_q ##1 !drv.chg_en || zv_q)
      else $error("Charger detection did not block charging.");
   a_xc_abandon: assert property (!xc_q && !xc_done |=> !xc_q)
      else $error("Charger flag set without full delay.");
   a_xc_release: assert property (xcr_done |=> !xc_q)
      else $error("Charger flag not released.");
   a_xc_suppress: assert property (!dis_hi |-> !xc_done)
      else $error("Charger detection ran with discharge blocked.");
   a_zero_volt: assert property (zv_q |=> drv.chg_en)
      else $error("Zero-volt charging not enabled.");
   a_och_blocks: assert property (och_done |=> och_q)
      else $error("Over-charge not latched.");
   a_od_standby: assert property (stby_q && cmp.stby_rel |=> !stby_q)
      else $error("Stand-by not released.");
   a_och_first_oc: assert property (och_q |-> !oc_done)
      else $error("Over-current detected after over-charge.");

   // =====================================================================
   // Checks on the release wait, the sense switches, stand-by and the charger delay.
   // =====================================================================
   // Cycles for which the discharge gate has been allowed, saturating.
   // The charger timer must never run ahead of this count.
   logic [prot_pkg::CNT_W-1:0] hi_run_q;

   // Any blocked cycle restarts the count, as the charger timer must.
   always_ff @(posedge clk)
   begin
      if (!rst_n || !dis_hi)
         hi_run_q <= '0;
      else if (hi_run_q != '1)
         hi_run_q <= hi_run_q + 1'b1;
   end

   sequence s_od_plain;
      dis_hi && od_done && !sc_done && !och_q;
   endsequence

   sequence s_od_after_och;
      dis_hi && od_done && !sc_done && och_q;
   endsequence

   sequence s_ocr_expire;
      dst_q == prot_pkg::D_OCREL && ocr_done;
   endsequence

   a_ocrel_holds_dis: assert property (dst_q == prot_pkg::D_OCREL |=> !drv.dis_en)
      else $error("Discharge gate opened before the release delay.");
   a_ocr_returns: assert property (s_ocr_expire
      |=> dst_q == prot_pkg::D_NORMAL ##1 drv.dis_en && !drv.pull_dn)
      else $error("Over-current release did not restore discharge.");
   a_pd_on_fault: assert property (!dis_hi && dst_q != prot_pkg::D_OD
      |=> drv.pull_dn && !drv.pull_up)
      else $error("Sense pull-down not applied after a current fault.");
   a_od_pullup: assert property (dst_q == prot_pkg::D_OD
      |=> drv.pull_up && !drv.pull_dn && !drv.dis_en)
      else $error("Over-discharge state drove wrong sense switches.");
   a_od_stby_entry: assert property (s_od_plain
      |=> stby_q && dst_q == prot_pkg::D_OD)
      else $error("Over-discharge did not enter stand-by.");
   a_od_no_stby: assert property (s_od_after_och
      |=> !stby_q && dst_q == prot_pkg::D_OD)
      else $error("Stand-by entered after over-charge.");
   a_och_first_rel: assert property (och_first_q && dis_hi
      |=> !drv.pull_up && !drv.pull_dn)
      else $error("Sense node not released after over-charge.");
   a_stby_only_od: assert property (stby_q |-> dst_q == prot_pkg::D_OD)
      else $error("Stand-by held outside the over-discharge state.");
   a_och_no_oc: assert property (och_q && dis_hi |=> dst_q != prot_pkg::D_OC)
      else $error("Over-current state entered after over-charge.");
   a_xc_waits_dis: assert property (xc_done
      |-> hi_run_q >= pick(prot_pkg::XC_CYC, tst))
      else $error("Charger delay started before discharge was allowed.");
endmodule : prot_seq

/* batt_env.sv */
`timescale 1ns/100ps
// =====================================================================
// Cells, charger and load as the comparators see them.
// =====================================================================
module batt_env
(
   input  wire logic [1:0] c1,   // Cell 1: 0 zero, 1 low, 2 mid, 3 high.
   input  wire logic [1:0] c2,   // Cell 2, same coding.
   input  wire logic [1:0] load, // 0 none, 1 over-current, 2 short.
   input  wire logic [1:0] chgr, // 0 none, 1 normal, 2 excessive.
   output prot_pkg::cmp_t  cmp   // Comparator levels.
);
   // A load keeps the sense node high even with the gate off, so a release needs it removed.
   always_comb
   begin
      cmp.over_charge = (c1 == 2'h3) || (c2 == 2'h3);
      cmp.charge_ok   = (c1 != 2'h3) && (c2 != 2'h3);
      cmp.over_dis    = (c1 <= 2'h1) || (c2 <= 2'h1);
      cmp.dis_ok      = (c1 >= 2'h2) && (c2 >= 2'h2);
      cmp.over_cur    = (load != 2'h0);
      cmp.short_cir   = (load == 2'h2);
      cmp.xs_charger  = (chgr == 2'h2);
      cmp.stby_rel    = (chgr != 2'h0);
      cmp.zero_v_ok   = (c1 == 2'h0) && (c2 == 2'h0) && (chgr != 2'h0);
   end
endmodule : batt_env

/* tb_prot_seq.sv */
`timescale 1ns/100ps
// =====================================================================
// Self-checking bench for the fault sequencer.
// =====================================================================
module tb_prot_seq;
   localparam int CHG = 4;
   localparam int DIS = 3;
   localparam int PU  = 2;
   localparam int PD  = 1;
   localparam int SB  = 0;
   logic           clk        = 1'b0;
   logic           rst_n      = 1'b0;
   logic           test_short = 1'b1;
   logic [1:0]     c1         = 2'h2;
   logic [1:0]     c2         = 2'h2;
   logic [1:0]     load       = 2'h0;
   logic [1:0]     chgr       = 2'h0;
   prot_pkg::cmp_t cmp;
   prot_pkg::drv_t drv;
   int             n_fail     = 0;
   int             num_checks = 0;
   int             n;

   // Half period of 2.5 ns gives 200 MHz.
   always #2.5 clk = ~clk;

   batt_env env (.c1(c1), .c2(c2), .load(load), .chgr(chgr), .cmp(cmp));
   prot_seq dut (.clk(clk), .rst_n(rst_n), .cmp_pins(cmp), .test_short(test_short), .drv(drv));

   // =====================================================================
   // Shared tasks.
   // =====================================================================
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task results();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc

   // Sampling on the falling edge keeps clear of the design's own updates.
   task lat(input int b, input logic v, input int bound);
      n = 0;
      while (drv[b] !== v)
      begin
         @(negedge clk);
         n++;
         if (n > bound)
         begin
            check(32'h1, 32'h0);
            results();
         end
      end
   endtask : lat

   // Synchronisers add a few cycles, so a small margin follows the delay.
   task dl(input int b, input logic v, input int d);
      lat(b, v, d + 40);
      check((n >= d) && (n <= d + 12), 32'h1);
   endtask : dl

   task hold(input int b, input logic v, input int k);
      int bad;
      bad = 0;
      repeat (k)
      begin
         @(negedge clk);
         if (drv[b] !== v)
            bad++;
      end
      check(bad, 32'h0);
   endtask : hold

   task do_reset(input logic ts);
      @(posedge clk);
      rst_n <= 1'b0;
      test_short <= ts;
      c1 <= 2'h2;
      c2 <= 2'h2;
      load <= 2'h0;
      chgr <= 2'h0;
      cyc(10);
      rst_n <= 1'b1;
      cyc(10);
   endtask : do_reset

   // =====================================================================
   // Scenarios.
   // =====================================================================
   task t_short();
      for (int ts = 0; ts < 2; ts++)
      begin
         do_reset(ts[0]);
         check(drv, 32'h18);
         @(posedge clk) load <= 2'h2;
         dl(DIS, 1'b0, 200);
         check({drv[PD], drv[SB]}, 32'h2);
         @(posedge clk) load <= 2'h0;
         dl(DIS, 1'b1, ts ? 250 : 2000);
         dl(PD, 1'b0, 0);
      end
   endtask : t_short

   task t_oc();
      do_reset(1'b0);
      @(posedge clk) load <= 2'h1;
      dl(DIS, 1'b0, 2000);
      do_reset(1'b1);
      @(posedge clk) load <= 2'h1;
      cyc(150);
      load <= 2'h0;
      cyc(20);
      load <= 2'h1;
      dl(DIS, 1'b0, 250);
   endtask : t_oc

   task t_xc();
      do_reset(1'b1);
      @(posedge clk) chgr <= 2'h2;
      cyc(200);
      chgr <= 2'h0;
      hold(CHG, 1'b1, 400);
      @(posedge clk) chgr <= 2'h2;
      dl(CHG, 1'b0, 375);
      @(posedge clk) chgr <= 2'h0;
      dl(CHG, 1'b1, 375);
   endtask : t_xc

   task t_od();
      do_reset(1'b1);
      @(posedge clk) c1 <= 2'h1;
      dl(DIS, 1'b0, 500);
      check({drv[PU], drv[SB]}, 32'h3);
      hold(SB, 1'b1, 300);
      @(posedge clk) chgr <= 2'h2;
      dl(SB, 1'b0, 0);
      hold(CHG, 1'b1, 500);
      @(posedge clk) c1 <= 2'h2;
      lat(DIS, 1'b1, 900);
      dl(CHG, 1'b0, 375);
   endtask : t_od

   task t_och();
      do_reset(1'b1);
      @(posedge clk) c1 <= 2'h3;
      dl(CHG, 1'b0, 500);
      check({drv[PU], drv[PD]}, 32'h0);
      @(posedge clk) load <= 2'h1;
      hold(DIS, 1'b1, 400);
      @(posedge clk) load <= 2'h0;
      c2 <= 2'h1;
      dl(DIS, 1'b0, 500);
      check({drv[PU], drv[SB]}, 32'h2);
   endtask : t_och

   task t_oc_first();
      do_reset(1'b1);
      @(posedge clk) load <= 2'h1;
      dl(DIS, 1'b0, 250);
      @(posedge clk) c1 <= 2'h3;
      dl(CHG, 1'b0, 500);
      check(drv[PD], 32'h1);
   endtask : t_oc_first

   // Charging is blocked first, so only the zero-volt path can reopen it quickly.
   task t_zero();
      do_reset(1'b1);
      @(posedge clk) c1 <= 2'h3;
      dl(CHG, 1'b0, 500);
      @(posedge clk) c1 <= 2'h0;
      c2 <= 2'h0;
      chgr <= 2'h1;
      dl(CHG, 1'b1, 0);
      hold(CHG, 1'b1, 600);
   endtask : t_zero

   // Main sequence, ending in the single verdict.
   initial
   begin
      t_short();
      t_oc();
      t_xc();
      t_od();
      t_och();
      t_oc_first();
      t_zero();
      results();
   end
endmodule : tb_prot_seq
